// >>> design/wwdt_top.sv
// Windowed watchdog timer with AHB-Lite register slave.
// Assumes hclk is the watchdog clock and a single-slave bus.
//
// Contract
// R1 - Valid feed copies reload into counter
// R2 - Reload writes below 0xFF store 0xFF
// R3 - Counter steps once per four clocks
// R4 - Protected early reload change causes reset
// R5 - Unprotected reload changes always accepted
// R6 - Feed above window is a watchdog event
// R7 - Window 0xFFFFFF disables windowing
// R8 - Warning raised one edge after crossing
// R9 - Warning flag set below compare value (code: sets it at or below)
// R10 - Warning compare zero gives no warning
// R11 - Enable is set-only; runs after feed
// R12 - Timeout sets the timeout flag
// R13 - Reset-enable option gates chip reset
// R14 - Lock bit blocks oscillator off; reset-only
// R15 - Software feeds before timeout
// R16 - Feed is word one then two
// R17 - Flags cleared individually by write-one
// R18 - Counter readable; timeout at zero
// R19 - Broken feed sequence is ignored
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module wwdt_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic chip_reset,
    output logic osc_lock
);
    // Captured address phase
    logic wr_q;
    logic [7:0] addr_q;
    // Mode, reload, window, warning, mask, counter, prescaler
    wwdt_pkg::wwdt_mode_t mode_q;
    logic running_q;
    logic [23:0] reload_q;
    logic [23:0] window_q;
    logic [9:0] warn_q;
    logic [1:0] mask_q;
    logic [23:0] count_q;
    logic [1:0] pre_q;
    wwdt_pkg::wwdt_feed_t feed_q;
    // Status flags and their set/clear terms
    logic [1:0] status;
    logic [1:0] st_clr;
    logic to_set;
    logic warn_set;
    logic warn_below_q;
    // Decoded write strobes
    logic wr_mode;
    logic wr_reload;
    logic wr_feed;
    logic wr_warn;
    logic wr_window;
    logic wr_status;
    logic wr_mask;
    logic feed_ok;
    logic tick;
    logic expire;
    logic bad_feed;
    logic bad_reload;
    logic addr_take;

    // Address phase is accepted every ready cycle; the slave has no waits
    assign addr_take = hsel && hready && htrans[1];

    // Capture address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            // Reads need no data-phase flag: hrdata loads in the address phase
            wr_q <= addr_take && hwrite;
            addr_q <= haddr;
        end
    end

    // Write decode; unmapped writes fall through and are ignored
    always_comb begin
        wr_mode = 1'b0;
        wr_reload = 1'b0;
        wr_feed = 1'b0;
        wr_warn = 1'b0;
        wr_window = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        if (!wr_q) begin
            wr_mode = 1'b0;
        end else if (addr_q == `WWDT_OFF_MODE) begin
            wr_mode = 1'b1;
        end else if (addr_q == `WWDT_OFF_RELOAD) begin
            wr_reload = 1'b1;
        end else if (addr_q == `WWDT_OFF_FEED) begin
            wr_feed = 1'b1;
        end else if (addr_q == `WWDT_OFF_WARN) begin
            wr_warn = 1'b1;
        end else if (addr_q == `WWDT_OFF_WINDOW) begin
            wr_window = 1'b1;
        end else if (addr_q == `WWDT_OFF_STATUS) begin
            wr_status = 1'b1;
        end else if (addr_q == `WWDT_OFF_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // Second word completes a feed only straight after the first [R16] [R19]
    assign feed_ok = wr_feed && (feed_q == wwdt_pkg::WWDT_FEED_ARMED)
        && (hwdata == `WWDT_FEED_TWO);

    // Feed sequencer: any other bus write breaks an armed sequence [R19]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feed_q <= wwdt_pkg::WWDT_FEED_IDLE;
        end else if (wr_feed && hwdata == `WWDT_FEED_ONE) begin
            feed_q <= wwdt_pkg::WWDT_FEED_ARMED; // [R16]
        end else if (wr_q) begin
            feed_q <= wwdt_pkg::WWDT_FEED_IDLE;
        end
    end

    // Feed while counter above window is an event, unless window is max
    assign bad_feed = feed_ok && running_q
        && (count_q > window_q); // [R6] [R7]
    // Protected reload change while still above warning and window
    assign bad_reload = wr_reload && mode_q.protect && running_q
        && (count_q > {14'h0000, warn_q}) && (count_q > window_q); // [R4]
    // Divide-by-four prescaler tick [R3]
    assign tick = running_q && (pre_q == `WWDT_PRESCALE);
    // Counter reaching zero is a timeout [R18]
    assign expire = tick && (count_q == 24'h000001);
    assign to_set = expire || bad_feed || bad_reload; // [R12]

    // Mode register: every bit is set-only; lock and enable cleared by reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= '0;
        end else if (wr_mode) begin
            mode_q <= mode_q | hwdata[3:0]; // [R11] [R14]
        end
    end

    // Running starts at the first feed after enable and never stops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_q <= 1'b0;
        end else if (mode_q.enable && feed_ok) begin
            running_q <= 1'b1; // [R11]
        end
    end

    // Reload register with floor; protect refuses early changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_q <= `WWDT_RELOAD_RST;
        end else if (wr_reload && !bad_reload) begin
            if (hwdata[23:0] < `WWDT_RELOAD_MIN) begin
                reload_q <= `WWDT_RELOAD_MIN; // [R2]
            end else begin
                reload_q <= hwdata[23:0]; // [R5]
            end
        end
    end

    // Window and warning compare registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            window_q <= `WWDT_WINDOW_RST;
            warn_q <= `WWDT_WARN_RST;
            mask_q <= 2'h0;
        end else begin
            if (wr_window) begin
                window_q <= hwdata[23:0];
            end
            if (wr_warn) begin
                warn_q <= hwdata[9:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata[1:0];
            end
        end
    end

    // Prescaler runs only while the watchdog runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 2'h0;
        end else if (!running_q || feed_ok) begin
            pre_q <= 2'h0;
        end else begin
            pre_q <= pre_q + 2'h1; // [R3]
        end
    end

    // Down-counter: a feed reloads, otherwise step on each tick until it holds at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= `WWDT_RELOAD_RST;
        end else if (feed_ok) begin
            count_q <= reload_q; // [R1]
        end else if (tick && count_q != 24'h000000) begin
            count_q <= count_q - 24'h000001; // [R18]
        end
    end

    // Compare registered, so the warning lands one edge after the crossing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warn_below_q <= 1'b0;
        end else begin
            warn_below_q <= running_q && (warn_q != 10'h000)
                && (count_q <= {14'h0000, warn_q}); // [R8] [R10]
        end
    end
    assign warn_set = warn_below_q; // [R9]

    // Write-one clears per flag [R17]
    assign st_clr = wr_status ? hwdata[1:0] : 2'h0;

    // Sticky timeout flag
    wwdt_sticky u_to (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_i(to_set),
        .clr_i(st_clr[`WWDT_ST_TIMEOUT]),
        .flag_o(status[`WWDT_ST_TIMEOUT])
    );
    // Sticky warning flag
    wwdt_sticky u_warn (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_i(warn_set),
        .clr_i(st_clr[`WWDT_ST_WARN]),
        .flag_o(status[`WWDT_ST_WARN])
    );

    // Outputs: chip reset pulse, interrupt level, oscillator lock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_reset <= 1'b0;
            irq <= 1'b0;
            osc_lock <= 1'b0;
        end else begin
            chip_reset <= to_set && mode_q.rst_en; // [R13] [R15]
            irq <= |(status & mask_q);
            osc_lock <= mode_q.lock; // [R14]
        end
    end

    // Read data: registered in the address phase so it stands in the data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            if (haddr == `WWDT_OFF_MODE) begin
                hrdata <= {28'h0000000, mode_q};
            end else if (haddr == `WWDT_OFF_RELOAD) begin
                hrdata <= {8'h00, reload_q};
            end else if (haddr == `WWDT_OFF_COUNT) begin
                hrdata <= {8'h00, count_q}; // [R18]
            end else if (haddr == `WWDT_OFF_WARN) begin
                hrdata <= {22'h000000, warn_q};
            end else if (haddr == `WWDT_OFF_WINDOW) begin
                hrdata <= {8'h00, window_q};
            end else if (haddr == `WWDT_OFF_STATUS) begin
                hrdata <= {30'h00000000, status};
            end else if (haddr == `WWDT_OFF_MASK) begin
                hrdata <= {30'h00000000, mask_q};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Feed reloads the counter on the next edge
    reload_copy_a: assert property ( // [R1]
        @(posedge hclk) disable iff (!hresetn)
        feed_ok |=> count_q == $past(reload_q)
    ) else $error("feed no reload");
    // Floor must hold whatever software writes
    reload_floor_a: assert property ( // [R2]
        @(posedge hclk) disable iff (!hresetn)
        reload_q >= 24'h0000FF
    ) else $error("reload below floor");
    // At most one step in any three clocks without a feed
    prescale_step_a: assert property ( // [R3]
        @(posedge hclk) disable iff (!hresetn)
        running_q && !feed_ok && count_q > 24'h000001
        ##1 feed_q == wwdt_pkg::WWDT_FEED_IDLE && !feed_ok
        ##1 !feed_ok ##1 !feed_ok
        |-> count_q >= $past(count_q, 3) - 24'h000001
    ) else $error("counter stepped too fast");
    // Refused reload change raises the event and keeps the old value
    protect_reset_a: assert property ( // [R4]
        @(posedge hclk) disable iff (!hresetn)
        bad_reload |=> status[0] && reload_q == $past(reload_q)
    ) else $error("protect breach missed");
    // Largest window value never restricts a feed
    window_event_a: assert property ( // [R7]
        @(posedge hclk) disable iff (!hresetn)
        feed_ok && running_q && window_q == 24'hFFFFFF |-> !bad_feed
    ) else $error("max window restricts");
    // Zero compare value never raises the warning
    warn_zero_a: assert property ( // [R10]
        @(posedge hclk) disable iff (!hresetn)
        warn_q == 10'h000 && $past(warn_q) == 10'h000 |-> !warn_set
    ) else $error("warning with zero compare");
    // Enable can only be set
    enable_sticky_a: assert property ( // [R11]
        @(posedge hclk) disable iff (!hresetn)
        mode_q.enable |=> mode_q.enable
    ) else $error("enable cleared");
    // Expiry always leaves the timeout flag set
    timeout_flag_a: assert property ( // [R12]
        @(posedge hclk) disable iff (!hresetn)
        expire |=> status[0] ##1 1'b1
    ) else $error("timeout flag lost");
    // Chip reset only after an event with reset-enable set
    reset_gate_a: assert property ( // [R13]
        @(posedge hclk) disable iff (!hresetn)
        chip_reset |-> $past(to_set) && $past(mode_q.rst_en)
    ) else $error("spurious chip reset");
    // Lock output never drops outside reset
    lock_hold_a: assert property ( // [R14]
        @(posedge hclk) disable iff (!hresetn)
        osc_lock |=> osc_lock
    ) else $error("lock dropped");
endmodule // wwdt_top

// >>> design/wwdt_defs.svh
// Constants for the windowed watchdog: register offsets, fields, resets.
// Assumes inclusion by wwdt_top and the testbench; the package does not include it.
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH
`define WWDT_OFF_MODE 8'h00
`define WWDT_OFF_RELOAD 8'h04
`define WWDT_OFF_FEED 8'h08
`define WWDT_OFF_COUNT 8'h0C
`define WWDT_OFF_WARN 8'h10
`define WWDT_OFF_WINDOW 8'h14
`define WWDT_OFF_STATUS 8'h18
`define WWDT_OFF_MASK 8'h1C
`define WWDT_MODE_EN 0
`define WWDT_MODE_RSTEN 1
`define WWDT_MODE_PROT 2
`define WWDT_MODE_LOCK 3
`define WWDT_ST_TIMEOUT 0
`define WWDT_ST_WARN 1
`define WWDT_RELOAD_MIN 24'h0000FF
`define WWDT_RELOAD_RST 24'h0000FF
`define WWDT_WINDOW_RST 24'hFFFFFF
`define WWDT_WARN_RST 10'h000
`define WWDT_FEED_ONE 32'h000000AA
`define WWDT_FEED_TWO 32'h00000055
`define WWDT_PRESCALE 2'h3
`endif

// >>> design/wwdt_pkg.sv
// Types shared by the windowed watchdog design.
// Assumes wwdt_defs.svh is on the include path.
package wwdt_pkg;
    // Feed sequence progress
    typedef enum logic [0:0] {
        WWDT_FEED_IDLE = 1'b0,
        WWDT_FEED_ARMED = 1'b1
    } wwdt_feed_t;
    // Mode bits held together
    typedef struct packed {
        logic lock;
        logic protect;
        logic rst_en;
        logic enable;
    } wwdt_mode_t;
endpackage

// >>> design/wwdt_sticky.sv
// One sticky status bit: hardware set beats a software clear.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module wwdt_sticky (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    // Set wins over clear so no event is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // wwdt_sticky

// >>> verif/tb_top.sv
// Self-checking bench for the windowed watchdog register block.
// Assumes wwdt_defs.svh on the include path and hclk as watchdog clock.
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, chip_reset, osc_lock;
    wire hready = hreadyout; // Single slave drives the bus ready
    int bad_count = 0;
    int checks = 0;
    int pulses = 0; // Chip reset pulses seen
    int exp_p = 0; // Model of expected pulses
    int cyc = 0;
    logic [31:0] r, c0, rnd;

    wwdt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .chip_reset(chip_reset), .osc_lock(osc_lock));

    // Free-running 100 MHz clock
    initial begin
        forever #5 hclk = ~hclk;
    end

    // Pulse counter and hang guard, a single watcher of the clock
    always @(posedge hclk) begin
        cyc++;
        if (chip_reset === 1'b1) pulses++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // Address phase held until ready, then data phase until ready
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= 1'b0;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata; // Taken at the edge closing the data phase
    endtask

    task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
        rd(a, r);
        chk(n, e, r);
        chk("hresp", 32'h00000000, {31'h00000000, hresp});
    endtask

    task automatic feed();
        wr(`WWDT_OFF_FEED, `WWDT_FEED_ONE);
        wr(`WWDT_OFF_FEED, `WWDT_FEED_TWO);
    endtask

    // Bounded wait for the next chip reset pulse, then compare counts
    task automatic wait_pulse();
        exp_p++;
        for (int i = 0; i < 1500 && pulses < exp_p; i++) @(posedge hclk);
        repeat (3) @(posedge hclk);
        chk("pulses", exp_p, pulses);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        void'($urandom(4532));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and an unmapped place
        rchk("reload", `WWDT_OFF_RELOAD, 32'h000000FF);
        rchk("window", `WWDT_OFF_WINDOW, 32'h00FFFFFF);
        rchk("warn", `WWDT_OFF_WARN, 32'h00000000);
        rchk("unmapped", 8'h20, 32'h00000000);
        // Reload floor and free changes while unprotected
        rnd = 32'h00000100 + ($urandom % 32'h00010000);
        wr(`WWDT_OFF_RELOAD, rnd);
        rchk("reload", `WWDT_OFF_RELOAD, rnd);
        // Broken feeds must not copy the new reload into the counter
        wr(`WWDT_OFF_FEED, `WWDT_FEED_ONE);
        wr(`WWDT_OFF_WARN, 32'h00000000);
        wr(`WWDT_OFF_FEED, `WWDT_FEED_TWO);
        wr(`WWDT_OFF_FEED, 32'h00000012);
        wr(`WWDT_OFF_FEED, `WWDT_FEED_TWO);
        repeat (20) @(posedge hclk);
        rchk("count_idle", `WWDT_OFF_COUNT, 32'h000000FF);
        wr(`WWDT_OFF_RELOAD, 32'h000000FE);
        rchk("reload", `WWDT_OFF_RELOAD, 32'h000000FF);
        // Enable is set-only
        wr(`WWDT_OFF_MODE, 32'h00000003);
        wr(`WWDT_OFF_MODE, 32'h00000000);
        rchk("mode", `WWDT_OFF_MODE, 32'h00000003);
        wr(`WWDT_OFF_MASK, 32'h00000003);
        // Valid feed loads reload, then one step per four clocks
        feed();
        rd(`WWDT_OFF_COUNT, c0);
        chk("count_load", 1, c0 <= 32'hFF && c0 >= 32'hFC);
        repeat (400) @(posedge hclk);
        rd(`WWDT_OFF_COUNT, r);
        chk("count_rate", 1, c0 - r >= 99 && c0 - r <= 101);
        // Starve the watchdog until it times out
        wait_pulse();
        rchk("status_to", `WWDT_OFF_STATUS, 32'h00000001);
        rchk("count_zero", `WWDT_OFF_COUNT, 32'h00000000);
        chk("irq_on", 1'b1, irq);
        wr(`WWDT_OFF_STATUS, 32'h00000001);
        repeat (3) @(posedge hclk);
        rchk("status_clr", `WWDT_OFF_STATUS, 32'h00000000);
        chk("irq_off", 1'b0, irq);
        // Warning once the count falls to the compare value
        // Feed first: a count parked at zero would trip the compare at once
        feed();
        wr(`WWDT_OFF_WARN, 32'h00000040);
        for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge hclk);
        rchk("status_wn", `WWDT_OFF_STATUS, 32'h00000002);
        rd(`WWDT_OFF_COUNT, r);
        chk("count_wn", 1, r <= 32'h40 && r >= 32'h3D);
        wr(`WWDT_OFF_MASK, 32'h00000001);
        repeat (3) @(posedge hclk);
        chk("irq_masked", 1'b0, irq);
        feed();
        // Feeding above the window is a watchdog event
        wr(`WWDT_OFF_WINDOW, 32'h00000080);
        feed();
        wait_pulse();
        rchk("status_win", `WWDT_OFF_STATUS, 32'h00000003);
        wr(`WWDT_OFF_STATUS, 32'h00000001);
        rchk("status_one", `WWDT_OFF_STATUS, 32'h00000002);
        wr(`WWDT_OFF_STATUS, 32'h00000002);
        rchk("status_clr2", `WWDT_OFF_STATUS, 32'h00000000);
        // Protected early reload change is refused and resets
        wr(`WWDT_OFF_MODE, 32'h00000004);
        wr(`WWDT_OFF_RELOAD, 32'h00000300);
        wait_pulse();
        rchk("reload_p", `WWDT_OFF_RELOAD, 32'h000000FF);
        // Oscillator lock holds until reset
        wr(`WWDT_OFF_MODE, 32'h00000008);
        wr(`WWDT_OFF_MODE, 32'h00000000);
        @(posedge hclk);
        chk("lock", 1'b1, osc_lock);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("lock_rst", 1'b0, osc_lock);
        rchk("mode_rst", `WWDT_OFF_MODE, 32'h00000000);
        // Timeout without reset-enable sets the flag but gives no pulse
        wr(`WWDT_OFF_MODE, 32'h00000001);
        feed();
        repeat (1100) @(posedge hclk);
        rchk("status_nr", `WWDT_OFF_STATUS, 32'h00000001);
        chk("no_pulse", exp_p, pulses);
        end_sim();
    end
endmodule // tb_top
